// ### pkg/twb_map.svh
`ifndef TWB_MAP_SVH
`define TWB_MAP_SVH

// Bit positions inside one byte on the wire
`define TWB_BIT_LAST 4'h7
`define TWB_BIT_ACK 4'h8
`define TWB_BIT_FIRST 4'h0
`define TWB_MSB 7
`define TWB_DIR_BIT 0

// Extension code patterns in the upper nibble of an address byte
`define TWB_EXT_LOW 4'h0
`define TWB_EXT_HIGH 4'hF

// Receive buffer depth and counter step
`define TWB_BUF_FULL 2'h2
`define TWB_CNT_STEP 9'h001
`define TWB_CNT_ZERO 8'h00

`endif

// ### pkg/twb_pkg.sv
package twb_pkg;

  // Sequencer states, Gray coded along start, wait, bits, stop
  typedef enum logic [2:0] {
    TWB_IDLE = 3'h0,
    TWB_MSTART = 3'h1,
    TWB_MSTART2 = 3'h3,
    TWB_WAIT = 3'h2,
    TWB_BITS = 3'h6,
    TWB_STOP = 3'h7,
    TWB_STOP2 = 3'h5,
    TWB_RSTART = 3'h4
  } twb_state_type;

  // Control bits and command strobes from software
  typedef struct packed {
    logic interface_enable;
    logic start_request;
    logic stop_request;
    logic ack_enable;
    logic wait_timing_select;
    logic stop_interrupt_enable;
    logic wait_release;
    logic tx_write;
    logic [6:0] own_slave_address;
    logic [7:0] tx_data;
    logic [7:0] clock_low_width;
    logic [7:0] clock_high_width;
  } twb_ctrl_type;

  // Status bits toward software
  typedef struct packed {
    logic start_detected;
    logic stop_detected;
    logic ack_detected;
    logic transmit_mode_flag;
    logic master_active;
    logic wait_active;
    logic [7:0] bus_shift_register;
  } twb_status_type;

  // Complete state of the bus engine
  typedef struct packed {
    twb_state_type st;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic scl_drv;
    logic sda_drv;
    logic [7:0] cnt;
    logic [3:0] bit_cnt;
    logic addr_phase;
    logic master;
    logic xmit;
    logic at8;
    logic dir;
    logic bus_busy;
    logic start_pend;
    logic start_det;
    logic stop_det;
    logic ack_det;
    logic irq;
    logic [7:0] shift;
    logic [1:0][7:0] buf_data;
    logic buf_w;
    logic buf_r;
    logic [1:0] buf_cnt;
  } twb_regs_type;

endpackage

// ### src/twb_bus_iface.sv
`timescale 1ns/1ps
`include "twb_map.svh"

// Function
// (RQ1) Clock and data pins are only pulled low, inputs sampled through synchronisers.
// (RQ2) Master holds clock low for low width, releases for high width count.
// (RQ3) Software picks master widths as fractions of bit period, rounding up.
// (RQ4) Software picks slave widths from fixed microsecond figures, truncating.
// (RQ5) Peripheral clock at least 3.5 MHz fast, 1 MHz standard.
// (RQ6) Master makes start, address byte, stop and drives the serial clock.
// (RQ7) Slave may stretch clock low; master high count waits for line high.
// (RQ8) Start is data falling while clock high; generated and detected.
// (RQ9) Start request emits start once bus free; any start sets start flag.
// (RQ10) Slave compares seven address bits, stays selected until start or stop.
// (RQ11) Foreign non-extension address raises no interrupt as slave.
// (RQ12) Written byte sends address in upper bits; received address kept in shift.
// (RQ13) Eighth address bit is direction: zero master writes, one master reads.
// (RQ14) Receiver pulls data low on ninth clock; transmitter samples it there.
// (RQ15) Acknowledge flag records whether the receiver acknowledged our byte.
// (RQ16) Master ends last read with no acknowledge, then stops or restarts.
// (RQ17) Data acknowledge only with ack enable; direction bit sets transmit flag.
// (RQ18) Receiver wanting no more bytes clears ack enable beforehand.
// (RQ19) Own address always acknowledged, foreign never, extension code if enabled.
// (RQ20) Eight clock wait: ack enable at release; nine clock wait: beforehand.
// (RQ21) Stop is data rising while clock high; stop request emits it.
// (RQ22) Stop sets stop flag; interrupt only with stop interrupt enable.
// (RQ23) With the interface disabled both pins are driven low.
// (RQ24) Lines are read as wired AND of all bus participants.
module twb_bus_iface (
  input wire logic mclk,
  input wire logic rst_n,
  input wire twb_pkg::twb_ctrl_type ctrl,
  output twb_pkg::twb_status_type status,
  output logic bus_interrupt,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready
);
  import twb_pkg::*;

  twb_regs_type r;
  twb_regs_type next_r;
  logic sclh;
  logic sdah;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic match;
  logic ext;
  logic push;
  logic pop;
  logic rel_ok;

  // Count reaches a programmed width (a width of zero acts as one)
  function automatic logic width_done(input logic [7:0] cnt, input logic [7:0] w);
    width_done = ({1'b0, cnt} + `TWB_CNT_STEP) >= {1'b0, w};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line view and bus events

  // (RQ24) wired AND view
  assign sclh = r.scl_sync[1];
  assign sdah = r.sda_sync[1];
  assign rise = sclh && !r.scl_prev;
  assign fall = !sclh && r.scl_prev;
  // (RQ8) start event seen
  assign start_ev = sclh && r.scl_prev && r.sda_prev && !sdah;
  // (RQ21) stop event seen
  assign stop_ev = sclh && r.scl_prev && !r.sda_prev && sdah;
  // (RQ10) address compare
  assign match = r.shift[7:1] == ctrl.own_slave_address;
  assign ext = (r.shift[7:4] == `TWB_EXT_LOW) || (r.shift[7:4] == `TWB_EXT_HIGH);
  assign pop = rx_valid && rx_ready;
  assign rel_ok = r.xmit || (r.buf_cnt != `TWB_BUF_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_r = r;
    push = 1'b0;
    next_r.scl_sync = {r.scl_sync[0], serial_clock_pin_in};
    next_r.sda_sync = {r.sda_sync[0], serial_data_pin_in};
    next_r.scl_prev = sclh;
    next_r.sda_prev = sdah;
    next_r.irq = 1'b0;
    if (pop)
    begin
      next_r.buf_r = !r.buf_r;
    end
    // (RQ9) request held until bus free
    if (ctrl.start_request)
    begin
      next_r.start_pend = 1'b1;
    end
    if (start_ev)
    begin
      // (RQ9) start flag set
      next_r.start_det = 1'b1;
      next_r.stop_det = 1'b0;
      next_r.bus_busy = 1'b1;
      // (RQ10) slave begins address byte
      if (!r.master)
      begin
        next_r.st = TWB_IDLE;
        next_r.bit_cnt = `TWB_BIT_FIRST;
        next_r.addr_phase = 1'b1;
        next_r.xmit = 1'b0;
        next_r.at8 = 1'b0;
        next_r.scl_drv = 1'b0;
        next_r.sda_drv = 1'b0;
      end
    end
    else if (stop_ev)
    begin
      // (RQ22) stop flag and interrupt
      next_r.stop_det = 1'b1;
      next_r.start_det = 1'b0;
      next_r.bus_busy = 1'b0;
      next_r.irq = ctrl.stop_interrupt_enable;
      next_r.st = TWB_IDLE;
      next_r.master = 1'b0;
      next_r.xmit = 1'b0;
      next_r.scl_drv = 1'b0;
      next_r.sda_drv = 1'b0;
    end
    else
    begin
      case (r.st)
        TWB_IDLE:
        begin
          next_r.scl_drv = 1'b0;
          next_r.sda_drv = 1'b0;
          // (RQ10) first clock fall after a start opens the address byte
          if (fall && r.addr_phase && r.bus_busy && !r.master)
          begin
            next_r.st = TWB_BITS;
          end
          // (RQ9) start once bus free
          if (r.start_pend && !r.bus_busy)
          begin
            next_r.master = 1'b1;
            next_r.start_pend = 1'b0;
            next_r.st = TWB_MSTART;
            next_r.cnt = `TWB_CNT_ZERO;
          end
        end
        TWB_MSTART:
        begin
          // (RQ8) data falls while clock high
          if (sclh)
          begin
            next_r.cnt = r.cnt + 8'h01;
            if (width_done(r.cnt, ctrl.clock_high_width))
            begin
              next_r.sda_drv = 1'b1;
              next_r.st = TWB_MSTART2;
              next_r.cnt = `TWB_CNT_ZERO;
            end
          end
        end
        TWB_MSTART2:
        begin
          // (RQ6) hold start, then own the clock
          next_r.cnt = r.cnt + 8'h01;
          if (width_done(r.cnt, ctrl.clock_high_width))
          begin
            next_r.scl_drv = 1'b1;
            next_r.st = TWB_WAIT;
            next_r.addr_phase = 1'b1;
            next_r.xmit = 1'b1;
            next_r.at8 = 1'b0;
            next_r.bit_cnt = `TWB_BIT_FIRST;
            next_r.cnt = `TWB_CNT_ZERO;
          end
        end
        TWB_WAIT:
        begin
          next_r.scl_drv = 1'b1;
          // (RQ12) byte written leaves MSB first
          if (ctrl.tx_write && rel_ok)
          begin
            next_r.shift = ctrl.tx_data;
            next_r.sda_drv = r.xmit && !ctrl.tx_data[`TWB_MSB];
            next_r.st = TWB_BITS;
            next_r.scl_drv = r.master;
            next_r.cnt = `TWB_CNT_ZERO;
          end
          // (RQ21) stop request from wait
          else if (ctrl.stop_request && r.master)
          begin
            next_r.sda_drv = 1'b1;
            next_r.st = TWB_STOP;
            next_r.cnt = `TWB_CNT_ZERO;
          end
          // (RQ16) repeated start from wait
          else if (ctrl.start_request && r.master)
          begin
            next_r.sda_drv = 1'b0;
            next_r.start_pend = 1'b0;
            next_r.st = TWB_RSTART;
            next_r.cnt = `TWB_CNT_ZERO;
          end
          else if (ctrl.wait_release && rel_ok)
          begin
            // (RQ20) ack decided at release
            next_r.sda_drv = r.at8 && !r.xmit && ctrl.ack_enable;
            next_r.st = TWB_BITS;
            next_r.scl_drv = r.master;
            next_r.cnt = `TWB_CNT_ZERO;
          end
        end
        TWB_RSTART:
        begin
          next_r.cnt = r.cnt + 8'h01;
          if (width_done(r.cnt, ctrl.clock_low_width))
          begin
            next_r.scl_drv = 1'b0;
            next_r.st = TWB_MSTART;
            next_r.cnt = `TWB_CNT_ZERO;
          end
        end
        TWB_STOP:
        begin
          next_r.cnt = r.cnt + 8'h01;
          if (width_done(r.cnt, ctrl.clock_low_width))
          begin
            next_r.scl_drv = 1'b0;
            next_r.st = TWB_STOP2;
            next_r.cnt = `TWB_CNT_ZERO;
          end
        end
        TWB_STOP2:
        begin
          // (RQ21) data rises while clock high
          if (sclh)
          begin
            next_r.cnt = r.cnt + 8'h01;
            if (width_done(r.cnt, ctrl.clock_high_width))
            begin
              next_r.sda_drv = 1'b0;
            end
          end
        end
        TWB_BITS:
        begin
          // (RQ2) low and high widths
          if (r.master)
          begin
            if (r.scl_drv)
            begin
              next_r.cnt = r.cnt + 8'h01;
              if (width_done(r.cnt, ctrl.clock_low_width))
              begin
                next_r.scl_drv = 1'b0;
                next_r.cnt = `TWB_CNT_ZERO;
              end
            end
            // (RQ7) high count waits for line
            else if (sclh)
            begin
              next_r.cnt = r.cnt + 8'h01;
              if (width_done(r.cnt, ctrl.clock_high_width))
              begin
                next_r.scl_drv = 1'b1;
                next_r.cnt = `TWB_CNT_ZERO;
              end
            end
          end
          if (rise)
          begin
            // (RQ15) transmitter samples ninth clock
            if (r.bit_cnt == `TWB_BIT_ACK)
            begin
              if (r.xmit)
              begin
                next_r.ack_det = !sdah;
              end
            end
            else
            begin
              next_r.shift = {r.shift[6:0], sdah};
            end
          end
          if (fall)
          begin
            if (r.bit_cnt < `TWB_BIT_LAST)
            begin
              next_r.bit_cnt = r.bit_cnt + 4'h1;
              next_r.sda_drv = r.xmit && !r.shift[`TWB_MSB];
            end
            else if (r.bit_cnt == `TWB_BIT_LAST)
            begin
              // (RQ14) transmitter frees data for ack
              next_r.bit_cnt = `TWB_BIT_ACK;
              next_r.sda_drv = 1'b0;
              // (RQ13) direction bit kept
              next_r.dir = r.shift[`TWB_DIR_BIT];
              if (r.addr_phase && !r.master)
              begin
                // (RQ19) own always, extension if enabled
                if (match || ext)
                begin
                  next_r.sda_drv = match || ctrl.ack_enable;
                end
                // (RQ11) foreign address, quiet
                else
                begin
                  next_r.st = TWB_IDLE;
                  next_r.addr_phase = 1'b0;
                end
              end
              else if (!r.addr_phase && !r.xmit)
              begin
                push = 1'b1;
                next_r.buf_data[r.buf_w] = r.shift;
                next_r.buf_w = !r.buf_w;
                // (RQ20) eight clock wait
                if (!ctrl.wait_timing_select)
                begin
                  next_r.at8 = 1'b1;
                  next_r.st = TWB_WAIT;
                  next_r.scl_drv = 1'b1;
                  next_r.irq = 1'b1;
                end
                // (RQ17) data ack from enable
                else
                begin
                  next_r.sda_drv = ctrl.ack_enable;
                end
              end
            end
            else
            begin
              next_r.bit_cnt = `TWB_BIT_FIRST;
              next_r.sda_drv = 1'b0;
              // (RQ17) transmit flag from direction
              if (r.addr_phase)
              begin
                next_r.addr_phase = 1'b0;
                next_r.xmit = r.master ? !r.dir : r.dir;
              end
              if (r.at8)
              begin
                next_r.at8 = 1'b0;
              end
              else
              begin
                next_r.st = TWB_WAIT;
                next_r.scl_drv = 1'b1;
                next_r.irq = 1'b1;
              end
            end
          end
        end
        default:
        begin
          next_r.st = TWB_IDLE;
        end
      endcase
    end
    next_r.buf_cnt = r.buf_cnt + {1'b0, push} - {1'b0, pop};
    // (RQ23) disabled pins held low
    if (!ctrl.interface_enable)
    begin
      next_r = '0;
      next_r.scl_drv = 1'b1;
      next_r.sda_drv = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // (RQ1) open drain, low only
  assign serial_clock_pin_out = 1'b0;
  assign serial_data_pin_out = 1'b0;
  assign serial_clock_pin_oe = r.scl_drv;
  assign serial_data_pin_oe = r.sda_drv;
  assign bus_interrupt = r.irq;
  // Receive buffer head
  assign rx_valid = r.buf_cnt != 2'h0;
  assign rx_data = r.buf_data[r.buf_r];
  // Status from state flops
  assign status.start_detected = r.start_det;
  assign status.stop_detected = r.stop_det;
  assign status.ack_detected = r.ack_det;
  assign status.transmit_mode_flag = r.xmit;
  assign status.master_active = r.master;
  assign status.wait_active = r.st == TWB_WAIT;
  assign status.bus_shift_register = r.shift;

endmodule

// ### tb/twb_bus_iface_sva.sv
`timescale 1ns/1ps
module twb_bus_iface_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire twb_pkg::twb_ctrl_type ctrl,
  input wire twb_pkg::twb_status_type status,
  input wire logic bus_interrupt,
  input wire logic serial_clock_pin_in,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready
);
  import twb_pkg::*;
  logic [8:0] lo_n;
  logic [8:0] hi_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Run lengths of clock drive and of clock line high, saturating
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      lo_n <= 9'h000;
      hi_n <= 9'h000;
    end
    else
    begin
      lo_n <= !serial_clock_pin_oe ? 9'h000 : lo_n + {8'h00, lo_n != 9'h1FF};
      hi_n <= !serial_clock_pin_in ? 9'h000 : hi_n + {8'h00, hi_n != 9'h1FF};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_open_drain:
    assert property (!serial_clock_pin_out && !serial_data_pin_out)
    else $error("pin output value not low");
  chk_disable_low:
    assert property (!ctrl.interface_enable ##1 !ctrl.interface_enable
      |-> serial_clock_pin_oe && serial_data_pin_oe)
    else $error("disabled pins not driven low");
  chk_low_width:
    assert property ($fell(serial_clock_pin_oe) && status.master_active
      |-> lo_n >= {1'b0, ctrl.clock_low_width})
    else $error("clock low phase too short");
  chk_high_width:
    assert property ($rose(serial_clock_pin_oe) && status.master_active
      |-> hi_n >= {1'b0, ctrl.clock_high_width})
    else $error("clock high phase too short");
  chk_start_flag:
    assert property ($fell(serial_data_pin_in) && serial_clock_pin_in
      && $past(serial_clock_pin_in) && ctrl.interface_enable |-> ##[1:6] status.start_detected)
    else $error("start not flagged");
  chk_stop_flag:
    assert property ($rose(serial_data_pin_in) && serial_clock_pin_in
      && $past(serial_clock_pin_in) && ctrl.interface_enable |-> ##[1:6] status.stop_detected)
    else $error("stop not flagged");
  chk_stop_irq:
    assert property ($rose(status.stop_detected) && ctrl.stop_interrupt_enable
      |-> (bus_interrupt || $past(bus_interrupt)) or (##[1:2] bus_interrupt))
    else $error("stop interrupt missing");
  chk_irq_pulse:
    assert property (bus_interrupt |=> !bus_interrupt)
    else $error("interrupt longer than one cycle");
  chk_wait_clock:
    assert property (status.wait_active |-> serial_clock_pin_oe)
    else $error("wait without clock held low");
  chk_buf_hold:
    assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("stalled byte lost");
endmodule

bind twb_bus_iface twb_bus_iface_chk i_chk (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl),
  .status(status), .bus_interrupt(bus_interrupt), .serial_clock_pin_in(serial_clock_pin_in),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_ready(rx_ready));

// ### tb/twb_peer.sv
`timescale 1ns/1ps
module twb_peer #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter int STRETCH = 40
) (
  input wire logic mclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe = 1'b0,
  output logic sda_oe = 1'b0,
  output logic [7:0] got
);
  logic ps = 1'b1;
  logic pd = 1'b1;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic adr = 1'b0;
  logic [3:0] n = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] nx;
  int hold = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Slave engine, acting one cycle after each line edge
  always @(posedge mclk)
  begin
    ps <= scl;
    pd <= sda;
    hold <= (hold > 0) ? hold - 1 : 0;
    scl_oe <= hold > 1;
    if (ps && scl && pd && !sda)
    begin
      {sel, adr, n, sda_oe} <= {2'b11, 4'hF, 1'b0}; // Fall after start brings zero
      rd <= 1'b0;
    end
    if (ps && scl && !pd && sda)
      {sel, sda_oe} <= 2'b00;
    if (!ps && scl && n < 4'h8)
      sh <= {sh[6:0], sda};
    if (!ps && scl && n == 4'h8 && rd && !adr && sda)
      sel <= 1'b0;
    if (ps && !scl && sel)
    begin
      n <= (n == 4'h8) ? 4'h0 : n + 4'h1;
      if (n < 4'h7 && rd && !adr)
        sda_oe <= !tx[4'h6 - n];
      if (n == 4'h7 && adr)
      begin
        sda_oe <= sh[7:1] == ADDR;
        sel <= sh[7:1] == ADDR;
        rd <= sh[0];
      end
      if (n == 4'h7 && !adr)
      begin
        sda_oe <= !rd;
        got <= rd ? got : sh;
      end
      if (n == 4'h8)
      begin
        nx = adr ? 8'hC3 : tx + 8'h11;
        hold <= STRETCH;
        adr <= 1'b0;
        tx <= nx;
        sda_oe <= rd && !nx[7];
      end
    end
  end
endmodule

// ### tb/tb_twb_bus_iface.sv
`timescale 1ns/1ps
module tb_twb_bus_iface;
  import twb_pkg::*;
  localparam logic [6:0] PEER = 7'h2A;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_ready = 1'b0;
  twb_ctrl_type ctrl;
  twb_status_type status;
  logic bus_interrupt, rx_valid, scl_oe, sda_oe, p_scl_oe, p_sda_oe;
  logic [7:0] rx_data, got;
  logic m_scl = 1'b0;
  logic m_sda = 1'b0;
  wire scl = !(scl_oe | p_scl_oe | m_scl);
  wire sda = !(sda_oe | p_sda_oe | m_sda);
  int n_mismatch = 0;
  int comparisons = 0;
  int n_irq = 0;
  int cyc = 0;
  int k;

  twb_bus_iface i_dut (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl), .status(status),
    .bus_interrupt(bus_interrupt), .serial_clock_pin_in(scl), .serial_clock_pin_out(),
    .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda), .serial_data_pin_out(),
    .serial_data_pin_oe(sda_oe), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready));
  twb_peer #(.ADDR(PEER)) i_peer (.mclk(mclk), .scl(scl), .sda(sda), .scl_oe(p_scl_oe),
    .sda_oe(p_sda_oe), .got(got));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, interrupt count and hang guard
  always #2.5 mclk = ~mclk;
  always @(negedge mclk)
  begin
    cyc++;
    if (bus_interrupt === 1'b1)
      n_irq++;
    if (cyc > 40000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One strobe: 0 start, 1 write, 2 release, 3 stop
  task automatic cmd(input int s, input logic [7:0] d);
    @(negedge mclk);
    ctrl.tx_data = d;
    ctrl.start_request = (s == 0);
    ctrl.tx_write = (s == 1);
    ctrl.wait_release = (s == 2);
    ctrl.stop_request = (s == 3);
    @(negedge mclk);
    {ctrl.start_request, ctrl.tx_write, ctrl.wait_release, ctrl.stop_request} = 4'h0;
    repeat (2) @(negedge mclk);
  endtask
  // Bounded wait for a wait state (0) or the stop flag (1)
  task automatic await(input int f);
    int i;
    i = 0;
    while ((f ? status.stop_detected : status.wait_active) !== 1'b1 && i < 5000)
    begin
      @(negedge mclk);
      i++;
    end
    if (i >= 5000)
      check(8'h00, 8'h01);
    repeat (3) @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hand made bus master: 1 pulls a line low
  task automatic bb_bit(input logic b, output logic seen);
    m_sda = !b;
    repeat (8) @(negedge mclk);
    m_scl = 1'b0;
    repeat (8) @(negedge mclk);
    seen = sda;
    m_scl = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
  task automatic bb_addr(input logic [7:0] d, output logic ack);
    logic s;
    m_sda = 1'b1;
    repeat (8) @(negedge mclk);
    m_scl = 1'b1;
    repeat (8) @(negedge mclk);
    for (int b = 7; b >= 0; b--)
      bb_bit(d[b], s);
    bb_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic bb_stop;
    m_sda = 1'b1;
    repeat (8) @(negedge mclk);
    m_scl = 1'b0;
    repeat (8) @(negedge mclk);
    m_sda = 1'b0;
    repeat (8) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_disabled;
    repeat (3) @(negedge mclk);
    check(8'({scl_oe, sda_oe}), 8'h03);
    ctrl.interface_enable = 1'b1;
    repeat (6) @(negedge mclk);
  endtask
  task automatic t_write;
    cmd(0, 8'h00);
    await(0);
    check(8'(status.master_active), 8'h01);
    check(8'(status.start_detected), 8'h01);
    cmd(1, {PEER, 1'b0});
    await(0);
    check(8'(status.ack_detected), 8'h01);
    check(8'(status.transmit_mode_flag), 8'h01);
    cmd(1, 8'h96);
    await(0);
    check(got, 8'h96);
    check(status.bus_shift_register, 8'h96);
    k = n_irq;
    cmd(3, 8'h00);
    await(1);
    check(8'(status.master_active), 8'h00);
    check(8'(n_irq - k), 8'h01);
  endtask
  task automatic t_nack;
    cmd(0, 8'h00);
    await(0);
    cmd(1, {7'h11, 1'b0});
    await(0);
    check(8'(status.ack_detected), 8'h00);
    ctrl.stop_interrupt_enable = 1'b0;
    k = n_irq;
    cmd(3, 8'h00);
    await(1);
    check(8'(n_irq - k), 8'h00);
    ctrl.stop_interrupt_enable = 1'b1;
  endtask
  task automatic t_read;
    cmd(0, 8'h00);
    await(0);
    cmd(1, {PEER, 1'b1});
    await(0);
    check(8'(status.transmit_mode_flag), 8'h00);
    ctrl.wait_timing_select = 1'b0;
    cmd(2, 8'h00);
    await(0);
    check(8'(sda_oe), 8'h00);
    check(status.bus_shift_register, 8'hC3);
    ctrl.wait_timing_select = 1'b1;
    cmd(2, 8'h00);
    ctrl.ack_enable = 1'b0;
    await(0);
    check(rx_data, 8'hC3);
    cmd(2, 8'h00);
    check(8'(status.wait_active), 8'h01);
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
    @(negedge mclk);
    check(rx_data, 8'hD4);
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
    @(negedge mclk);
    check(8'(rx_valid), 8'h00);
    cmd(3, 8'h00);
    await(1);
    ctrl.ack_enable = 1'b1;
  endtask
  task automatic t_slave;
    logic a;
    k = n_irq;
    bb_addr({7'h33, 1'b0}, a);
    check(8'(a), 8'h01);
    check(8'(status.wait_active), 8'h01);
    check(status.bus_shift_register, 8'h66);
    check(8'(n_irq - k), 8'h01);
    cmd(2, 8'h00);
    bb_stop();
    k = n_irq;
    bb_addr({7'h55, 1'b0}, a);
    check(8'(a), 8'h00);
    check(8'(status.wait_active), 8'h00);
    check(8'(n_irq - k), 8'h00);
    bb_stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset, then the scenarios in turn
  initial
  begin
    ctrl = '0;
    ctrl.clock_low_width = 8'h06;
    ctrl.clock_high_width = 8'h05;
    ctrl.own_slave_address = 7'h33;
    ctrl.ack_enable = 1'b1;
    ctrl.wait_timing_select = 1'b1;
    ctrl.stop_interrupt_enable = 1'b1;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    t_disabled();
    t_write();
    t_nack();
    t_read();
    t_slave();
    wrap_up();
  end
endmodule
